// [gpio_pkg.sv]
// package of register offsets, reset values and widths for the four-port gpio block
package gpio_pkg;
    // ****************************************
    // register map (byte addresses on apb)
    // ****************************************
    localparam logic [7:0] OFS_OD_LATCH   = 8'h00;
    localparam logic [7:0] OFS_OD_DIR     = 8'h04;
    localparam logic [7:0] OFS_KEY_LATCH  = 8'h08;
    localparam logic [7:0] OFS_KEY_DIR    = 8'h0C;
    localparam logic [7:0] OFS_KEY_PU     = 8'h10;
    localparam logic [7:0] OFS_AN_LATCH   = 8'h14;
    localparam logic [7:0] OFS_AN_DIR     = 8'h18;
    localparam logic [7:0] OFS_CLK_LATCH  = 8'h1C;
    localparam logic [7:0] OFS_CLK_DIR    = 8'h20;
    localparam logic [7:0] OFS_CLK_PU     = 8'h24;
    localparam logic [7:0] OFS_AN_CFG     = 8'h28;
    localparam logic [7:0] OFS_OSC_MODE   = 8'h2C;
    localparam logic [7:0] OFS_SERIAL     = 8'h30;
    localparam logic [7:0] OFS_STATUS     = 8'h34;
    // ****************************************
    // widths and reset values
    // ****************************************
    localparam int OD_W  = 2;
    localparam int KEY_W = 6;
    localparam int AN_W  = 4;
    localparam int CLK_W = 5;
    localparam logic [7:0] DIR_RESET   = 8'hFF;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] PU_RESET    = 8'h00;
    localparam logic [7:0] OSC_RESET   = 8'h00;
    localparam logic [7:0] SER_RESET   = 8'h00;
    localparam logic [3:0] CFG_RESET   = 4'h0;
    // oscillator mode field positions
    localparam int OSC_MAIN_BIT = 0;
    localparam int OSC_SUB_BIT  = 1;
endpackage : gpio_pkg

// [gpio_ports.sv]
// gpio logic for the open-drain, key-input, analog-shared and clock-shared ports
// Functional notes
// - open-drain pins each have own direction bit
// - open-drain pins only pull low, never high
// - reset puts open-drain pins in input
// - open-drain input path stays on in output
// - key-input pins each have own direction bit
// - key pull-up only when input and enabled
// - reset puts key-input pins in input
// - key pin levels feed key-return detection
// - analog pins each have own direction bit
// - reset makes analog pins digital inputs
// - amplifier input pins legal modes, else prohibited
// - amplifier output pin legal modes, else prohibited
// - plain analog pin legal modes, else prohibited
// - clock pins each have own direction bit
// - only interrupt-shared clock pin has pull-up
// - reset puts clock pins in input
// - oscillator mode resets 00H, takes crystal pins
// - direction zero output, one input
// - direction registers reset to all ones
module gpio_ports (
    // clock and reset
    input  wire logic                      ref_clk_in,
    input  wire logic                      rst_in,
    // apb slave
    input  wire logic                      psel_in,
    input  wire logic                      penable_in,
    input  wire logic                      pwrite_in,
    input  wire logic [7:0]                paddr_in,
    input  wire logic [31:0]               pwdata_in,
    output logic      [31:0]               prdata_out,
    output logic                           pready_out,
    output logic                           pslverr_out,
    // open-drain port
    input  wire logic [gpio_pkg::OD_W-1:0] od_pin_in,
    output logic      [gpio_pkg::OD_W-1:0] od_pin_out,
    output logic      [gpio_pkg::OD_W-1:0] od_pin_oe_out,
    // key-input port
    input  wire logic [gpio_pkg::KEY_W-1:0] key_pin_in,
    output logic      [gpio_pkg::KEY_W-1:0] key_pin_out,
    output logic      [gpio_pkg::KEY_W-1:0] key_pin_oe_out,
    output logic      [gpio_pkg::KEY_W-1:0] key_pullup_out,
    output logic      [gpio_pkg::KEY_W-1:0] key_return_input_out,
    // analog-shared port
    input  wire logic [gpio_pkg::AN_W-1:0] an_pin_in,
    output logic      [gpio_pkg::AN_W-1:0] an_pin_out,
    output logic      [gpio_pkg::AN_W-1:0] an_pin_oe_out,
    output logic      [gpio_pkg::AN_W-1:0] an_analog_sel_out,
    output logic      [gpio_pkg::AN_W-1:0] an_convert_out,
    output logic                           amp_route_out,
    output logic                           an_prohibited_out,
    // clock-shared port
    input  wire logic [gpio_pkg::CLK_W-1:0] clk_pin_in,
    output logic      [gpio_pkg::CLK_W-1:0] clk_pin_out,
    output logic      [gpio_pkg::CLK_W-1:0] clk_pin_oe_out,
    output logic      [gpio_pkg::CLK_W-1:0] clk_pullup_out,
    output logic      [gpio_pkg::CLK_W-1:0] clk_osc_owned_out,
    // peripheral control levels
    input  wire logic [3:0]                converter_channel_select_in,
    input  wire logic                      amplifier_enable_in
);
    import gpio_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [OD_W-1:0]  od_latch;
        logic [OD_W-1:0]  opendrain_port_direction;
        logic [KEY_W-1:0] key_latch;
        logic [KEY_W-1:0] keyin_port_direction;
        logic [KEY_W-1:0] keyin_pullup_enable;
        logic [AN_W-1:0]  an_latch;
        logic [AN_W-1:0]  analog_port_direction;
        logic [CLK_W-1:0] clk_latch;
        logic [CLK_W-1:0] clkpin_port_direction;
        logic             clkpin_pullup_enable;
        logic [3:0]       analog_digital_pin_config;
        logic [7:0]       oscillator_mode_select;
        logic [7:0]       serial_mode_reg;
        logic [7:0]       serial_clock_select_reg;
        logic [31:0]      rdata;
        logic             slverr;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [31:0] rd_val;
    logic        hit;
    logic        acc;
    logic [AN_W-1:0] an_sel;
    logic [CLK_W-1:0] osc_own;

    // ****************************************
    // read mux and decode
    // ****************************************
    assign acc = psel_in && penable_in;
    // one-hot selection of the converter channel among this port
    always_comb begin
        an_sel = '0;
        if (converter_channel_select_in[3:2] == 2'h2) begin
            an_sel[converter_channel_select_in[1:0]] = 1'b1;
        end
    end
    // crystal pins taken by oscillator mode
    assign osc_own = {{2{s_q.oscillator_mode_select[OSC_SUB_BIT]}},
                      {2{s_q.oscillator_mode_select[OSC_MAIN_BIT]}}, 1'b0};

    always_comb begin
        rd_val = 32'h0000_0000;
        hit    = 1'b1;
        unique case (paddr_in)
            // open-drain pins always read the pin level
            OFS_OD_LATCH:  rd_val[OD_W-1:0] = od_pin_in;
            OFS_OD_DIR:    rd_val[OD_W-1:0] = s_q.opendrain_port_direction;
            OFS_KEY_LATCH: rd_val[KEY_W-1:0] = (s_q.keyin_port_direction & key_pin_in)
                                             | (~s_q.keyin_port_direction & s_q.key_latch);
            OFS_KEY_DIR:   rd_val[KEY_W-1:0] = s_q.keyin_port_direction;
            OFS_KEY_PU:    rd_val[KEY_W-1:0] = s_q.keyin_pullup_enable;
            OFS_AN_LATCH:  rd_val[AN_W-1:0] = (s_q.analog_port_direction & an_pin_in)
                                            | (~s_q.analog_port_direction & s_q.an_latch);
            OFS_AN_DIR:    rd_val[AN_W-1:0] = s_q.analog_port_direction;
            OFS_CLK_LATCH: rd_val[CLK_W-1:0] = (s_q.clkpin_port_direction & clk_pin_in)
                                             | (~s_q.clkpin_port_direction & s_q.clk_latch);
            OFS_CLK_DIR:   rd_val[CLK_W-1:0] = s_q.clkpin_port_direction;
            OFS_CLK_PU:    rd_val[0] = s_q.clkpin_pullup_enable;
            OFS_AN_CFG:    rd_val[3:0] = s_q.analog_digital_pin_config;
            OFS_OSC_MODE:  rd_val[7:0] = s_q.oscillator_mode_select;
            OFS_SERIAL:    rd_val[15:0] = {s_q.serial_clock_select_reg, s_q.serial_mode_reg};
            OFS_STATUS:    rd_val[0] = an_prohibited_out;
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        if (acc && pwrite_in && hit) begin
            unique case (paddr_in)
                OFS_OD_LATCH:  s_d.od_latch = pwdata_in[OD_W-1:0];
                OFS_OD_DIR:    s_d.opendrain_port_direction = pwdata_in[OD_W-1:0];
                OFS_KEY_LATCH: s_d.key_latch = pwdata_in[KEY_W-1:0];
                OFS_KEY_DIR:   s_d.keyin_port_direction = pwdata_in[KEY_W-1:0];
                OFS_KEY_PU:    s_d.keyin_pullup_enable = pwdata_in[KEY_W-1:0];
                OFS_AN_LATCH:  s_d.an_latch = pwdata_in[AN_W-1:0];
                OFS_AN_DIR:    s_d.analog_port_direction = pwdata_in[AN_W-1:0];
                OFS_CLK_LATCH: s_d.clk_latch = pwdata_in[CLK_W-1:0];
                OFS_CLK_DIR:   s_d.clkpin_port_direction = pwdata_in[CLK_W-1:0];
                OFS_CLK_PU:    s_d.clkpin_pullup_enable = pwdata_in[0];
                OFS_AN_CFG:    s_d.analog_digital_pin_config = pwdata_in[3:0];
                OFS_OSC_MODE:  s_d.oscillator_mode_select = pwdata_in[7:0];
                OFS_SERIAL: begin
                    s_d.serial_mode_reg = pwdata_in[7:0];
                    s_d.serial_clock_select_reg = pwdata_in[15:8];
                end
                default: begin
                    s_d.slverr = 1'b0;
                end
            endcase
        end
        // read word and error flag taken at the setup edge,
        // so both stand from flip-flops in the access phase
        if (psel_in && !penable_in) begin
            s_d.rdata  = rd_val;
            s_d.slverr = ~hit;
        end
        if (rst_in) begin
            s_d.od_latch                  = LATCH_RESET[OD_W-1:0];
            s_d.opendrain_port_direction  = DIR_RESET[OD_W-1:0];
            s_d.key_latch                 = LATCH_RESET[KEY_W-1:0];
            s_d.keyin_port_direction      = DIR_RESET[KEY_W-1:0];
            s_d.keyin_pullup_enable       = PU_RESET[KEY_W-1:0];
            s_d.an_latch                  = LATCH_RESET[AN_W-1:0];
            s_d.analog_port_direction     = DIR_RESET[AN_W-1:0];
            s_d.clk_latch                 = LATCH_RESET[CLK_W-1:0];
            s_d.clkpin_port_direction     = DIR_RESET[CLK_W-1:0];
            s_d.clkpin_pullup_enable      = PU_RESET[0];
            s_d.analog_digital_pin_config = CFG_RESET;
            s_d.oscillator_mode_select    = OSC_RESET;
            s_d.serial_mode_reg           = SER_RESET;
            s_d.serial_clock_select_reg   = SER_RESET;
            s_d.rdata                     = 32'h0000_0000;
            s_d.slverr                    = 1'b0;
        end
    end

    // state register
    always_ff @(posedge ref_clk_in) begin
        s_q <= s_d;
    end

    // ****************************************
    // apb answer
    // ****************************************
    assign pready_out  = 1'b1; // zero wait states
    assign prdata_out  = s_q.rdata; // held from the setup edge
    assign pslverr_out = acc && s_q.slverr;

    // ****************************************
    // pin drivers
    // ****************************************
    // open-drain: drive low only, release on latch one
    assign od_pin_out    = '0;
    assign od_pin_oe_out = ~s_q.opendrain_port_direction & ~s_q.od_latch;

    // key-input port, pull-up only in input mode
    assign key_pin_out          = s_q.key_latch;
    assign key_pin_oe_out       = ~s_q.keyin_port_direction;
    assign key_pullup_out       = s_q.keyin_port_direction & s_q.keyin_pullup_enable;
    assign key_return_input_out = key_pin_in;

    // analog port: digital buffer off when analog selected
    genvar gi;
    generate
        for (gi = 0; gi < AN_W; gi++) begin : g_an
            assign an_pin_out[gi]    = s_q.an_latch[gi];
            assign an_pin_oe_out[gi] = ~s_q.analog_port_direction[gi]
                                     & ~s_q.analog_digital_pin_config[gi];
            assign an_analog_sel_out[gi] = s_q.analog_digital_pin_config[gi];
            // pin 1 carries amp output when enabled; pins 0, 2 feed amp
            assign an_convert_out[gi] = s_q.analog_digital_pin_config[gi] & an_sel[gi];
        end
    endgenerate
    assign amp_route_out = amplifier_enable_in & (&s_q.analog_digital_pin_config[2:0]);

    // prohibited combination flag
    always_comb begin
        an_prohibited_out = 1'b0;
        // amplifier enabled while an amp pin is digital
        if (amplifier_enable_in && !(&s_q.analog_digital_pin_config[2:0])) begin
            an_prohibited_out = 1'b1;
        end
        // amplifier input selected for conversion
        if (amplifier_enable_in && (an_sel[0] || an_sel[2])) begin
            an_prohibited_out = 1'b1;
        end
        // analog mode with output direction
        if (|(s_q.analog_digital_pin_config & ~s_q.analog_port_direction)) begin
            an_prohibited_out = 1'b1;
        end
    end

    // clock port: crystal pins override direction and latch
    assign clk_pin_out       = s_q.clk_latch & ~osc_own;
    assign clk_pin_oe_out    = ~s_q.clkpin_port_direction & ~osc_own;
    assign clk_pullup_out    = {{(CLK_W-1){1'b0}},
                                s_q.clkpin_port_direction[0] & s_q.clkpin_pullup_enable};
    assign clk_osc_owned_out = osc_own;

    // ****************************************
    // assertions
    // ****************************************
    // open-drain port
    a_od_never_high: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (od_pin_oe_out & s_q.od_latch) == '0)
        else $error("open-drain drives with latch one");

    a_od_reset_in: assert property (@(posedge ref_clk_in)
        rst_in |=> od_pin_oe_out == '0)
        else $error("open-drain not input after reset");

    a_od_dir_write: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        acc && pwrite_in && paddr_in == OFS_OD_DIR |=>
        s_q.opendrain_port_direction == $past(pwdata_in[OD_W-1:0]))
        else $error("open-drain direction not written");

    a_od_read_pin: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        acc && !pwrite_in && paddr_in == OFS_OD_LATCH |->
        prdata_out[OD_W-1:0] == $past(od_pin_in))
        else $error("open-drain read not pin level");

    // key-input port
    a_key_reset_in: assert property (@(posedge ref_clk_in)
        rst_in |=> key_pin_oe_out == '0 && key_pullup_out == '0)
        else $error("key pins not input");

    a_key_pu_gate: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (key_pullup_out & key_pin_oe_out) == '0)
        else $error("pull-up on output pin");

    a_dir_write: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        acc && pwrite_in && paddr_in == OFS_KEY_DIR |=>
        key_pin_oe_out == ~$past(pwdata_in[KEY_W-1:0]))
        else $error("key direction not written");

    a_key_read: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        acc && !pwrite_in && paddr_in == OFS_KEY_LATCH && s_q.keyin_port_direction == '1
        |-> prdata_out[KEY_W-1:0] == $past(key_pin_in))
        else $error("key read not pin level");

    a_key_return: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        key_return_input_out == key_pin_in)
        else $error("key return level differs from pin");

    // analog-shared port
    a_an_reset_dig: assert property (@(posedge ref_clk_in)
        rst_in |=> an_analog_sel_out == '0 && an_pin_oe_out == '0)
        else $error("analog not digital in");

    a_an_dir_write: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        acc && pwrite_in && paddr_in == OFS_AN_DIR |=>
        s_q.analog_port_direction == $past(pwdata_in[AN_W-1:0]))
        else $error("analog direction not written");

    a_an_no_drive: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (an_pin_oe_out & an_analog_sel_out) == '0)
        else $error("analog pin drives digitally");

    a_amp_route: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        amp_route_out |-> amplifier_enable_in && an_analog_sel_out[2:0] == 3'h7)
        else $error("amplifier routed without analog pins");

    // clock-shared port
    a_clk_reset_in: assert property (@(posedge ref_clk_in)
        rst_in |=> clk_pin_oe_out == '0 && clk_osc_owned_out == '0)
        else $error("clock pins not input");

    a_clk_pu_only: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        clk_pullup_out[CLK_W-1:1] == '0)
        else $error("pull-up on wrong clock pin");

    a_osc_take: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (clk_pin_oe_out & clk_osc_owned_out) == '0)
        else $error("crystal pin driven");

    a_clk_dir_write: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        acc && pwrite_in && paddr_in == OFS_CLK_DIR |=>
        s_q.clkpin_port_direction == $past(pwdata_in[CLK_W-1:0]))
        else $error("clock direction not written");

    // main scenarios reached
    c_od_drive_low: cover property (@(posedge ref_clk_in) od_pin_oe_out != '0);
    c_amp_route: cover property (@(posedge ref_clk_in) amp_route_out);
    c_osc_owned: cover property (@(posedge ref_clk_in) clk_osc_owned_out != '0);
    c_key_pullup: cover property (@(posedge ref_clk_in) key_pullup_out != '0);
    c_an_prohib: cover property (@(posedge ref_clk_in) an_prohibited_out);
endmodule : gpio_ports

// [pin_world.sv]
// far-side model of the circuitry wired to the port pins
module pin_world (
    // clock
    input  wire logic        ref_clk_in,
    // far-side drivers, one bit a pin
    input  wire logic [16:0] ext_en_in,
    input  wire logic [16:0] ext_val_in,
    // device pin controls, one bit a pin
    input  wire logic [16:0] drv_in,
    input  wire logic [16:0] oe_in,
    input  wire logic [16:0] pu_in,
    // resolved wire levels
    output logic      [16:0] lvl_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic flip = 1'b0;

    // undriven floating wires wander every cycle
    always @(posedge ref_clk_in) begin
        flip <= ~flip;
    end

    // device driver wins, then far side, then pull-up, else floating
    always_comb begin
        for (int i = 0; i < 17; i++) begin
            lvl_out[i] = oe_in[i] ? drv_in[i] : ext_en_in[i] ? ext_val_in[i] : pu_in[i] ? 1'b1 : flip ^ i[0];
        end
    end
endmodule : pin_world

// [multi_port_gpio_ports_6_7_8_12_test.sv]
// self-checking bench of the four-port gpio block against a behavioural model
module multi_port_gpio_ports_6_7_8_12_test;
    timeunit 1ns;
    timeprecision 100ps;
    import gpio_pkg::*;
    // ****************************************
    // signals and model state
    // ****************************************
    logic        ref_clk_in = 1'b0;
    logic        rst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, amplifier_enable_in;
    logic [7:0]  paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd, rng;
    logic [1:0]  od_pin_in, od_pin_out, od_pin_oe_out;
    logic [5:0]  key_pin_in, key_pin_out, key_pin_oe_out, key_pullup_out, key_return_input_out;
    logic [3:0]  an_pin_in, an_pin_out, an_pin_oe_out, an_analog_sel_out, an_convert_out, converter_channel_select_in;
    logic        amp_route_out, an_prohibited_out, se;
    logic [4:0]  clk_pin_in, clk_pin_out, clk_pin_oe_out, clk_pullup_out, clk_osc_owned_out;
    logic [16:0] ext_en, ext_val, lvl, snap;
    logic [31:0] m [14];
    logic [31:0] rmask [14] = '{32'h3, 32'h3, 32'h3F, 32'h3F, 32'h3F, 32'hF, 32'hF, 32'h1F, 32'h1F, 32'h1, 32'hF,
                                32'h3, 32'hFFFF, 32'h1};
    int          err_total, compares;

    // clock and pin wiring
    always #12.5 ref_clk_in = ~ref_clk_in;
    assign {clk_pin_in, an_pin_in, key_pin_in, od_pin_in} = lvl;

    gpio_ports i_gpio_ports (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .od_pin_in(od_pin_in), .od_pin_out(od_pin_out),
        .od_pin_oe_out(od_pin_oe_out), .key_pin_in(key_pin_in), .key_pin_out(key_pin_out),
        .key_pin_oe_out(key_pin_oe_out), .key_pullup_out(key_pullup_out), .key_return_input_out(key_return_input_out),
        .an_pin_in(an_pin_in), .an_pin_out(an_pin_out), .an_pin_oe_out(an_pin_oe_out),
        .an_analog_sel_out(an_analog_sel_out), .an_convert_out(an_convert_out), .amp_route_out(amp_route_out),
        .an_prohibited_out(an_prohibited_out), .clk_pin_in(clk_pin_in), .clk_pin_out(clk_pin_out),
        .clk_pin_oe_out(clk_pin_oe_out), .clk_pullup_out(clk_pullup_out), .clk_osc_owned_out(clk_osc_owned_out),
        .converter_channel_select_in(converter_channel_select_in), .amplifier_enable_in(amplifier_enable_in));

    pin_world i_pin_world (.ref_clk_in(ref_clk_in), .ext_en_in(ext_en), .ext_val_in(ext_val),
        .drv_in({clk_pin_out, an_pin_out, key_pin_out, od_pin_out}),
        .oe_in({clk_pin_oe_out, an_pin_oe_out, key_pin_oe_out, od_pin_oe_out}),
        .pu_in({clk_pullup_out, 4'h0, key_pullup_out, 2'h3}), .lvl_out(lvl));
    // ****************************************
    // helpers and model
    // ****************************************
    function logic [31:0] xorshift();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xorshift

    function logic [4:0] own();
        return {m[11][1], m[11][1], m[11][0], m[11][0], 1'b0};
    endfunction : own

    function logic [3:0] selv();
        return (converter_channel_select_in >= 4'h8 && converter_channel_select_in <= 4'hB) ?
               4'(4'h1 << (converter_channel_select_in - 4'h8)) : 4'h0;
    endfunction : selv

    function logic prohib();
        logic [3:0] c, d, s;
        logic       a;
        c = 4'(m[10]);
        d = 4'(m[6]);
        s = selv();
        a = amplifier_enable_in;
        return (c[0] ? (!d[0] | (a & s[0])) : a) | (c[2] ? (!d[2] | (a & s[2])) : a) | (c[1] ? !d[1] : a) | (c[3] & !d[3]);
    endfunction : prohib

    task model_reset();
        for (int i = 0; i < 14; i++) begin
            m[i] = (i == 1 || i == 3 || i == 6 || i == 8) ? (32'(DIR_RESET) & rmask[i]) : 32'h0;
        end
    endtask : model_reset

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask : chk

    // one apb transfer, held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge ref_clk_in);
        snap = lvl; // pin levels the design captures for a read
        penable_in <= 1'b1;
        n = 0;
        @(posedge ref_clk_in);
        while (pready_out !== 1'b1 && n < 16) begin
            @(posedge ref_clk_in);
            n++;
        end
        rd = prdata_out;
        se = pslverr_out;
        if (n == 16) begin
            $display("ERROR pready expected 1 seen %b", pready_out);
            err_total++;
        end
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge ref_clk_in);
    endtask : apb

    task read_all();
        logic [31:0] e, k;
        for (int i = 0; i < 14; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            e = m[i];
            k = rmask[i];
            case (i)
                0: e = snap[1:0];
                2: e = (m[3] & snap[7:2]) | (~m[3] & m[2]);
                5: begin
                    e = (m[6] & snap[11:8]) | (~m[6] & m[5]);
                    k = k & ~m[10];
                end
                7: begin
                    e = (m[8] & snap[16:12]) | (~m[8] & m[7]);
                    k = k & ~32'(own());
                end
                13: e = prohib();
                default: e = m[i];
            endcase
            chk($sformatf("read %0d", i), e & k, rd & k);
            chk("pslverr", 32'h0, se);
        end
    endtask : read_all

    task check_outs();
        chk("od_oe", ~m[1] & ~m[0] & 32'h3, od_pin_oe_out);
        chk("od_out", 32'h0, od_pin_out);
        chk("key_oe", ~m[3] & 32'h3F, key_pin_oe_out);
        chk("key_out", m[2], key_pin_out);
        chk("key_pu", m[3] & m[4], key_pullup_out);
        chk("key_ret", key_pin_in, key_return_input_out);
        chk("an_oe", ~m[6] & ~m[10] & 32'hF, an_pin_oe_out);
        chk("an_sel", m[10], an_analog_sel_out);
        chk("an_conv", m[10] & selv(), an_convert_out);
        chk("amp", amplifier_enable_in & (m[10][2:0] == 3'h7), amp_route_out);
        chk("prohib", prohib(), an_prohibited_out);
        chk("clk_oe", ~m[8] & ~32'(own()) & 32'h1F, clk_pin_oe_out);
        chk("clk_pu", m[8] & m[9] & 32'h1, clk_pullup_out);
        chk("clk_own", own(), clk_osc_owned_out);
        chk("clk_out", m[7] & ~32'(own()), clk_pin_out);
    endtask : check_outs

    task conclude();
        if (err_total == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude
    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        logic [31:0] t;
        rst_in = 1'b1;
        {psel_in, penable_in, pwrite_in, amplifier_enable_in} = 4'h0;
        {paddr_in, pwdata_in, converter_channel_select_in, ext_en, ext_val} = '0;
        rng = 32'h66DDF161;
        err_total = 0;
        compares = 0;
        model_reset();
        repeat (3) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        @(negedge ref_clk_in);
        check_outs();
        @(posedge ref_clk_in);
        read_all();
        for (int r = 0; r < 40; r++) begin
            t = xorshift();
            ext_en <= t[16:0];
            ext_val <= 17'(xorshift());
            converter_channel_select_in <= t[17] ? {2'h2, t[19:18]} : t[23:20];
            amplifier_enable_in <= t[24];
            for (int i = 0; i < 14; i++) begin
                t = xorshift();
                if (i == 12) begin
                    t = 32'h0;
                end
                apb(1'b1, 8'(4 * i), t);
                chk("pslverr", 32'h0, se);
                if (i < 13) m[i] = t & rmask[i];
            end
            @(negedge ref_clk_in);
            check_outs();
            @(posedge ref_clk_in);
            read_all();
        end
        // unmapped place refuses both directions
        apb(1'b1, 8'h38, 32'hFFFFFFFF);
        chk("unmapped wr err", 32'h1, se);
        apb(1'b0, 8'h38, 32'h0);
        chk("unmapped rd err", 32'h1, se);
        chk("unmapped rd data", 32'h0, rd);
        read_all();
        // reset in mid-run returns every pin to input
        rst_in <= 1'b1;
        @(posedge ref_clk_in);
        rst_in <= 1'b0;
        model_reset();
        @(negedge ref_clk_in);
        check_outs();
        @(posedge ref_clk_in);
        read_all();
        conclude();
    end

    // hang guard, far beyond the expected run length
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        err_total++;
        $display("ERROR watchdog expected finish seen timeout");
        conclude();
    end
endmodule : multi_port_gpio_ports_6_7_8_12_test
